// ---- uplink_command_register_map.vh ----
// Purpose: constants for the uplink command register block
// Assumes: 32-bit AHB-Lite register window, word aligned
// Notes: included by its bare name; definitions only
//
// Notes on behaviour
// - commands enter as 16-bit words on receiver clock
// - top nibble zero: normal command, flag, hold data
// - nonzero nibble picks target in a logic unit
// - overriding data and address go to all units
// - input instruction selects command, else telemetry register
// - uses telemetry control section input-write level
// - word-complete passes two-stage word-strobe synchronizer
// - transfer pulse copies word, one strobe period
// - transfer sets flag; address zero shows it
// - input instruction sets shift control, twelve shifts
// - normal command: shift control, flag cleared first pulse after strobe
// - pulse counter cleared by strobe, set by pulse
// - nonzero address sets shift control without instruction
// - strobe after override clears address and control
`ifndef UPLINK_COMMAND_REGISTER_MAP_VH
`define UPLINK_COMMAND_REGISTER_MAP_VH

// ---------------------------------------------------------------
// word layout
// ---------------------------------------------------------------
`define UCR_WORD_BITS 16
`define UCR_DATA_BITS 12
`define UCR_ADDR_BITS 4
`define UCR_ADDR_MSB 15
`define UCR_ADDR_LSB 12
`define UCR_DATA_MSB 11
`define UCR_SHIFT_COUNT 4'hC
`define UCR_CNT_BITS 4
`define UCR_NORMAL_ADDR 4'h0

// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define UCR_OFF_STATUS 8'h00
`define UCR_OFF_MASK 8'h04
`define UCR_OFF_CTRL 8'h08
`define UCR_OFF_WORD 8'h0C
`define UCR_OFF_STATE 8'h10

// ---------------------------------------------------------------
// status and mask bits
// ---------------------------------------------------------------
`define UCR_EVT_BITS 3
`define UCR_EVT_WORD 0
`define UCR_EVT_OVR 1
`define UCR_EVT_READ 2

// ---------------------------------------------------------------
// control bits and reset values
// ---------------------------------------------------------------
`define UCR_CTRL_RX_EN 0
`define UCR_CTRL_RESET 1'h1
`define UCR_MASK_RESET 3'h0

// ---------------------------------------------------------------
// state register fields
// ---------------------------------------------------------------
`define UCR_ST_FLAG 0
`define UCR_ST_SHIFT 1
`define UCR_ST_COUNTER 2
`define UCR_ST_DONE 3
`define UCR_ST_SYNC_LSB 4
`define UCR_ST_ADDR_LSB 8
`define UCR_ST_CNT_LSB 12

// ---------------------------------------------------------------
// synchroniser lane positions
// ---------------------------------------------------------------
`define UCR_SYNC_BITS 7
`define UCR_LN_LINK_CLK 0
`define UCR_LN_LINK_DATA 1
`define UCR_LN_WORD_DONE 2
`define UCR_LN_SHIFT 3
`define UCR_LN_STROBE 4
`define UCR_LN_INPUT_WRITE_LEVEL 5
`define UCR_LN_INP_INSTR 6

`endif

// ---- pin_synchronizer.v ----
// Purpose: two flip-flop synchroniser for a group of pin levels
// Assumes: each lane is an independent level
// Notes: first stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none

module pin_synchronizer #(
  parameter WIDTH = 1
) (
  input wire clk_i,
  input wire rst_i,
  input wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      stage1 <= {WIDTH{1'b0}};
      stage2 <= {WIDTH{1'b0}};
    end else begin
      stage1 <= async_i;
      stage2 <= stage1;
    end
  end

  assign sync_o = stage2;

endmodule // pin_synchronizer

`default_nettype wire

// ---- uplink_command_register.v ----
// Purpose: uplink command register with AHB-Lite status window
// Assumes: all timing pins asynchronous to CORE_CLK_I
// Notes: edges of link clock, shift and strobe pulses found by sampling
//
// Design decisions made here: register access over AHB-Lite and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "uplink_command_register_map.vh"

module uplink_command_register #(
  parameter MSB_FIRST = 1
) (
  input wire CORE_CLK_I,
  input wire RST_I,
  input wire HSEL_I,
  input wire [31:0] HADDR_I,
  input wire [1:0] HTRANS_I,
  input wire HWRITE_I,
  input wire [2:0] HSIZE_I,
  input wire [31:0] HWDATA_I,
  input wire HREADY_I,
  output reg [31:0] HRDATA_O,
  output reg HREADYOUT_O,
  output reg HRESP_O,
  input wire LINK_CLK_I,
  input wire LINK_DATA_I,
  input wire WORD_COMPLETE_LEVEL_I,
  input wire SHIFT_PULSE_I,
  input wire WORD_STROBE_PULSE_I,
  input wire INPUT_WRITE_LEVEL_I,
  input wire INPUT_INSTRUCTION_I,
  output reg [3:0] CMD_ADDR_O,
  output reg CMD_DATA_O,
  output reg CMD_SHIFT_O,
  output reg INPUT_FLAG_O,
  output reg TELEMETRY_SELECT_O,
  output reg IRQ_O
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  wire [`UCR_SYNC_BITS-1:0] pins_async;
  wire [`UCR_SYNC_BITS-1:0] pins;

  assign pins_async = {INPUT_INSTRUCTION_I, INPUT_WRITE_LEVEL_I, WORD_STROBE_PULSE_I,
                       SHIFT_PULSE_I, WORD_COMPLETE_LEVEL_I, LINK_DATA_I, LINK_CLK_I};

  pin_synchronizer #(
    .WIDTH(`UCR_SYNC_BITS)
  ) u_sync (
    .clk_i(CORE_CLK_I),
    .rst_i(RST_I),
    .async_i(pins_async),
    .sync_o(pins)
  );

  // ---------------------------------------------------------------
  // edge detection on synchronised levels
  // ---------------------------------------------------------------
  reg link_clk_d;
  reg shift_d;
  reg strobe_d;
  wire link_rise;
  wire sc_edge;
  wire ws_edge;
  wire input_access;

  always @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      link_clk_d <= 1'b0;
      shift_d <= 1'b0;
      strobe_d <= 1'b0;
    end else begin
      link_clk_d <= pins[`UCR_LN_LINK_CLK];
      shift_d <= pins[`UCR_LN_SHIFT];
      strobe_d <= pins[`UCR_LN_STROBE];
    end
  end

  assign link_rise = pins[`UCR_LN_LINK_CLK] & ~link_clk_d;
  assign sc_edge = pins[`UCR_LN_SHIFT] & ~shift_d;
  assign ws_edge = pins[`UCR_LN_STROBE] & ~strobe_d;
  // input instruction reaching this address, write level from telemetry control
  assign input_access = pins[`UCR_LN_INP_INSTR] & pins[`UCR_LN_INPUT_WRITE_LEVEL];

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  reg rx_enable;
  reg [`UCR_EVT_BITS-1:0] status;
  reg [`UCR_EVT_BITS-1:0] mask;

  // ---------------------------------------------------------------
  // upper shift register on receiver clock
  // ---------------------------------------------------------------
  reg [`UCR_WORD_BITS-1:0] upper;

  always @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      upper <= {`UCR_WORD_BITS{1'b0}};
    end else if (link_rise && rx_enable) begin
      upper <= {upper[`UCR_WORD_BITS-2:0], pins[`UCR_LN_LINK_DATA]};
    end
  end

  // ---------------------------------------------------------------
  // word-complete synchroniser on word strobe
  // ---------------------------------------------------------------
  reg wc_stage1;
  reg wc_stage2;
  wire transfer_level;
  wire transfer_start;

  always @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      wc_stage1 <= 1'b0;
      wc_stage2 <= 1'b0;
    end else if (ws_edge) begin
      wc_stage1 <= pins[`UCR_LN_WORD_DONE];
      wc_stage2 <= wc_stage1;
    end
  end

  assign transfer_level = wc_stage1 & ~wc_stage2;
  assign transfer_start = ws_edge & pins[`UCR_LN_WORD_DONE] & ~wc_stage1;

  // ---------------------------------------------------------------
  // lower register, address register, control flip-flops
  // ---------------------------------------------------------------
  reg [`UCR_DATA_BITS-1:0] lower;
  reg [`UCR_ADDR_BITS-1:0] cmd_addr;
  reg [`UCR_WORD_BITS-1:0] last_word;
  reg flag;
  reg shift_ctl;
  reg pulse_counter;
  reg delivered;
  reg [`UCR_CNT_BITS-1:0] shift_cnt;
  wire normal_cmd;
  wire second_pulse;
  wire first_pulse;
  wire shift_now;
  wire start_shift;
  wire override_end;
  wire normal_end;

  assign normal_cmd = (cmd_addr == `UCR_NORMAL_ADDR);
  assign second_pulse = sc_edge & pulse_counter;
  assign first_pulse = sc_edge & ~pulse_counter;
  assign shift_now = sc_edge & shift_ctl & (shift_cnt != `UCR_SHIFT_COUNT) &
                     ~first_pulse;
  assign start_shift = second_pulse & ~shift_ctl & ~delivered & flag & ~transfer_level &
                       (normal_cmd ? input_access : 1'b1);
  assign override_end = ws_edge & shift_ctl & ~normal_cmd &
                        (shift_cnt == `UCR_SHIFT_COUNT);
  assign normal_end = first_pulse & shift_ctl & normal_cmd &
                      (shift_cnt == `UCR_SHIFT_COUNT);

  // pulse counter: clear on strobe, set on shift pulse
  always @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pulse_counter <= 1'b0;
    end else if (ws_edge) begin
      pulse_counter <= 1'b0;
    end else if (sc_edge) begin
      pulse_counter <= 1'b1;
    end
  end

  // word transfer and address register
  always @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      cmd_addr <= {`UCR_ADDR_BITS{1'b0}};
      last_word <= {`UCR_WORD_BITS{1'b0}};
    end else if (transfer_start) begin
      cmd_addr <= upper[`UCR_ADDR_MSB:`UCR_ADDR_LSB];
      last_word <= upper;
    end else if (override_end) begin
      cmd_addr <= {`UCR_ADDR_BITS{1'b0}};
    end
  end

  // lower data register: load on transfer, shift on enabled pulses
  always @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      lower <= {`UCR_DATA_BITS{1'b0}};
    end else if (transfer_start) begin
      lower <= upper[`UCR_DATA_MSB:0];
    end else if (shift_now) begin
      if (MSB_FIRST != 0) begin
        lower <= {lower[`UCR_DATA_BITS-2:0], 1'b0};
      end else begin
        lower <= {1'b0, lower[`UCR_DATA_BITS-1:1]};
      end
    end
  end

  // set-reset flag: set by transfer, cleared after read or delivery
  always @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      flag <= 1'b0;
    end else if (transfer_start) begin
      flag <= 1'b1;
    end else if (normal_end || override_end) begin
      flag <= 1'b0;
    end
  end

  // shift control flip-flop and its pulse count
  always @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      shift_ctl <= 1'b0;
      shift_cnt <= {`UCR_CNT_BITS{1'b0}};
    end else if (normal_end || override_end) begin
      shift_ctl <= 1'b0;
      shift_cnt <= {`UCR_CNT_BITS{1'b0}};
    end else if (start_shift) begin
      shift_ctl <= 1'b1;
      shift_cnt <= {`UCR_CNT_BITS{1'b0}};
    end else if (shift_now) begin
      shift_cnt <= shift_cnt + 4'h1;
    end
  end

  // delivered: blocks a second delivery of the same word
  always @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      delivered <= 1'b0;
    end else if (transfer_start) begin
      delivered <= 1'b0;
    end else if (normal_end || override_end) begin
      delivered <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // outputs toward logic units and input channel
  // ---------------------------------------------------------------
  always @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      CMD_ADDR_O <= 4'h0;
      CMD_DATA_O <= 1'b0;
      CMD_SHIFT_O <= 1'b0;
      INPUT_FLAG_O <= 1'b0;
      TELEMETRY_SELECT_O <= 1'b1;
    end else begin
      CMD_ADDR_O <= cmd_addr;
      CMD_SHIFT_O <= shift_now;
      if (MSB_FIRST != 0) begin
        CMD_DATA_O <= lower[`UCR_DATA_BITS-1];
      end else begin
        CMD_DATA_O <= lower[0];
      end
      INPUT_FLAG_O <= flag & normal_cmd;
      TELEMETRY_SELECT_O <= ~pins[`UCR_LN_INP_INSTR];
    end
  end

  // ---------------------------------------------------------------
  // event status, mask and interrupt
  // ---------------------------------------------------------------
  reg ahb_pending;
  reg ahb_write;
  reg [7:0] ahb_addr;
  wire addr_phase;
  wire [`UCR_EVT_BITS-1:0] events;
  wire [`UCR_EVT_BITS-1:0] w1c;

  assign events = {normal_end, override_end, transfer_start};
  assign w1c = (ahb_pending && ahb_write && ahb_addr == `UCR_OFF_STATUS) ?
               HWDATA_I[`UCR_EVT_BITS-1:0] : {`UCR_EVT_BITS{1'b0}};

  // set wins over clear
  always @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      status <= {`UCR_EVT_BITS{1'b0}};
      IRQ_O <= 1'b0;
    end else begin
      status <= (status & ~w1c) | events;
      IRQ_O <= |(((status & ~w1c) | events) & mask);
    end
  end

  // ---------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ---------------------------------------------------------------
  assign addr_phase = HSEL_I & HREADY_I & HTRANS_I[1];

  always @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ahb_pending <= 1'b0;
      ahb_write <= 1'b0;
      ahb_addr <= 8'h00;
      HREADYOUT_O <= 1'b1;
      HRESP_O <= 1'b0;
    end else begin
      HREADYOUT_O <= 1'b1;
      HRESP_O <= 1'b0;
      if (HREADY_I) begin
        ahb_pending <= addr_phase;
        ahb_write <= HWRITE_I;
        ahb_addr <= HADDR_I[7:0];
      end
    end
  end

  // register writes in data phase
  always @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      mask <= `UCR_MASK_RESET;
      rx_enable <= `UCR_CTRL_RESET;
    end else if (ahb_pending && ahb_write) begin
      if (ahb_addr == `UCR_OFF_MASK) begin
        mask <= HWDATA_I[`UCR_EVT_BITS-1:0];
      end
      if (ahb_addr == `UCR_OFF_CTRL) begin
        rx_enable <= HWDATA_I[`UCR_CTRL_RX_EN];
      end
    end
  end

  // read data chosen in address phase, driven in data phase
  reg [31:0] next_rdata;

  always @* begin
    next_rdata = 32'h00000000;
    case (HADDR_I[7:0])
      `UCR_OFF_STATUS: begin
        next_rdata[`UCR_EVT_BITS-1:0] = status;
      end
      `UCR_OFF_MASK: begin
        next_rdata[`UCR_EVT_BITS-1:0] = mask;
      end
      `UCR_OFF_CTRL: begin
        next_rdata[`UCR_CTRL_RX_EN] = rx_enable;
      end
      `UCR_OFF_WORD: begin
        next_rdata[`UCR_WORD_BITS-1:0] = last_word;
      end
      `UCR_OFF_STATE: begin
        next_rdata[`UCR_ST_FLAG] = flag;
        next_rdata[`UCR_ST_SHIFT] = shift_ctl;
        next_rdata[`UCR_ST_COUNTER] = pulse_counter;
        next_rdata[`UCR_ST_DONE] = delivered;
        next_rdata[`UCR_ST_SYNC_LSB] = wc_stage1;
        next_rdata[`UCR_ST_SYNC_LSB+1] = wc_stage2;
        next_rdata[`UCR_ST_ADDR_LSB+`UCR_ADDR_BITS-1:`UCR_ST_ADDR_LSB] = cmd_addr;
        next_rdata[`UCR_ST_CNT_LSB+`UCR_CNT_BITS-1:`UCR_ST_CNT_LSB] = shift_cnt;
      end
      default: begin
        next_rdata = 32'h00000000;
      end
    endcase
  end

  always @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      HRDATA_O <= 32'h00000000;
    end else if (addr_phase && !HWRITE_I) begin
      HRDATA_O <= next_rdata;
    end
  end

endmodule // uplink_command_register

`default_nettype wire

// ---- uplink_command_register_properties.sv ----
// Purpose: timing properties of the uplink command register pins
// Assumes: strobe pin sampled on the core clock
// Notes: bound to the top module, sees its ports only
`timescale 1ns/10ps
`default_nettype none

module uplink_command_register_properties (
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic WORD_STROBE_PULSE_I,
  input wire logic INPUT_INSTRUCTION_I,
  input wire logic [3:0] CMD_ADDR_O,
  input wire logic CMD_SHIFT_O,
  input wire logic INPUT_FLAG_O,
  input wire logic TELEMETRY_SELECT_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);
  logic ws_q;
  logic [7:0] since_ws;
  logic [3:0] shifts;
  // ---------------------------------------------------------------
  // strobe age and shift count
  // ---------------------------------------------------------------
  always @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ws_q <= 1'h0;
      since_ws <= 8'hFF;
      shifts <= 4'h0;
    end else begin
      ws_q <= WORD_STROBE_PULSE_I;
      if (WORD_STROBE_PULSE_I && !ws_q) since_ws <= 8'h00;
      else if (since_ws != 8'hFF) since_ws <= since_ws + 8'h01;
      if (since_ws == 8'h02) shifts <= 4'h0;
      else if (CMD_SHIFT_O) shifts <= shifts + 4'h1;
    end
  end
  sequence instr_on;
    INPUT_INSTRUCTION_I [*5];
  endsequence
  sequence instr_off;
    !INPUT_INSTRUCTION_I [*5];
  endsequence
  select_low_a: assert property (instr_on |-> !TELEMETRY_SELECT_O)
    else $error("command register not selected");
  select_high_a: assert property (instr_off |-> TELEMETRY_SELECT_O)
    else $error("telemetry register not selected");
  flag_addr_a: assert property (INPUT_FLAG_O |-> CMD_ADDR_O == 4'h0)
    else $error("flag shown for nonzero address");
  shift_pulse_a: assert property (CMD_SHIFT_O |=> !CMD_SHIFT_O)
    else $error("shift longer than one cycle");
  shift_cause_a: assert property (CMD_SHIFT_O |-> CMD_ADDR_O != 4'h0 || !TELEMETRY_SELECT_O)
    else $error("shift without override or input");
  shift_count_a: assert property (CMD_SHIFT_O |-> shifts < 4'hC)
    else $error("more than twelve shifts");
  shift_late_a: assert property (CMD_SHIFT_O |-> since_ws > 8'h11)
    else $error("shift on first or second pulse");
  addr_change_a: assert property ($changed(CMD_ADDR_O) |-> since_ws < 8'h0A)
    else $error("address changed away from strobe");
  flag_clear_a: assert property ($fell(INPUT_FLAG_O) |-> since_ws inside {[8'h06:8'h14]})
    else $error("flag cleared off first pulse");
endmodule // uplink_command_register_properties

bind uplink_command_register uplink_command_register_properties u_props (
  .CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .WORD_STROBE_PULSE_I(WORD_STROBE_PULSE_I),
  .INPUT_INSTRUCTION_I(INPUT_INSTRUCTION_I), .CMD_ADDR_O(CMD_ADDR_O),
  .CMD_SHIFT_O(CMD_SHIFT_O), .INPUT_FLAG_O(INPUT_FLAG_O),
  .TELEMETRY_SELECT_O(TELEMETRY_SELECT_O)
);
`default_nettype wire

// ---- uplink_receiver_model.sv ----
// Purpose: uplink command receiver sending one word per request
// Assumes: link clock still between frames
// Notes: prompt or slow completion
`timescale 1ns/10ps
`default_nettype none

module uplink_receiver_model (
  input wire logic go_i,
  input wire logic slow_i,
  input wire logic [15:0] word_i,
  output logic link_clk_o,
  output logic link_data_o,
  output logic complete_o
);
  initial begin
    link_clk_o = 1'h0;
    link_data_o = 1'h0;
    complete_o = 1'h0;
  end
  // ---------------------------------------------------------------
  // frame
  // ---------------------------------------------------------------
  always @(posedge go_i) begin
    // keep link edges off core clock edges
    #1.25;
    complete_o = 1'h0;
    for (int i = 15; i >= 0; i--) begin
      link_data_o = word_i[i];
      #32 link_clk_o = 1'h1;
      #32 link_clk_o = 1'h0;
    end
    link_data_o = ~link_data_o;
    if (slow_i) #200;
    complete_o = 1'h1;
  end
endmodule // uplink_receiver_model
`default_nettype wire

// ---- test_uplink_command_register.sv ----
// Purpose: self-checking bench for uplink command register
// Assumes: strobe and shift pins driven on the core clock
// Notes: random words with corner addresses and data
`timescale 1ns/10ps
`default_nettype none
`include "uplink_command_register_map.vh"

module test_uplink_command_register;
  logic clk = 1'h0, rst = 1'h1, hsel = 1'h0, hwrite = 1'h0, ws = 1'h0, sc = 1'h0;
  logic ins = 1'h0, iwl = 1'h0, go = 1'h0, slow = 1'h0, dq = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, seed = 32'h7602B853, r, hrdata;
  logic [15:0] wv = 16'h0;
  logic [11:0] got = 12'h0;
  logic [3:0] addr;
  logic lclk, ldat, cpl, hready, hresp, sh, dat, flag, tsel, irq;
  int miscompares = 0, tests_run = 0, nsh = 0, cyc = 0;
  always #2.5 clk = ~clk;
  uplink_command_register DUT (
    .CORE_CLK_I(clk), .RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp), .LINK_CLK_I(lclk),
    .LINK_DATA_I(ldat), .WORD_COMPLETE_LEVEL_I(cpl), .SHIFT_PULSE_I(sc),
    .WORD_STROBE_PULSE_I(ws), .INPUT_WRITE_LEVEL_I(iwl), .INPUT_INSTRUCTION_I(ins),
    .CMD_ADDR_O(addr), .CMD_DATA_O(dat), .CMD_SHIFT_O(sh), .INPUT_FLAG_O(flag),
    .TELEMETRY_SELECT_O(tsel), .IRQ_O(irq)
  );
  uplink_receiver_model rx (.go_i(go), .slow_i(slow), .word_i(wv), .link_clk_o(lclk),
    .link_data_o(ldat), .complete_o(cpl));
  // ---------------------------------------------------------------
  // monitor and tasks
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (sh === 1'h1) begin
      nsh++;
      got = {got[10:0], dq};
    end
    dq = dat;
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      results;
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [31:0] exp_status(input logic [3:0] a);
    return (32'h1 << `UCR_EVT_WORD) |
           (32'h1 << ((a != `UCR_NORMAL_ADDR) ? `UCR_EVT_OVR : `UCR_EVT_READ));
  endfunction
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task results;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'h1) @(posedge clk);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'h1) @(posedge clk);
    r = hrdata;
    chk(hresp, 32'h0);
  endtask
  task per(input int np);
    nsh = 0;
    repeat (4) @(posedge clk);
    ws <= 1'h1;
    repeat (3) @(posedge clk);
    ws <= 1'h0;
    repeat (3) @(posedge clk);
    repeat (np) begin
      sc <= 1'h1;
      repeat (3) @(posedge clk);
      sc <= 1'h0;
      repeat (3) @(posedge clk);
    end
    repeat (8) @(posedge clk);
  endtask
  task cmd(input logic [3:0] a, input logic [11:0] d);
    wv <= {a, d};
    @(posedge clk);
    go <= 1'h1;
    @(posedge clk);
    go <= 1'h0;
    per(0);
    while (cpl !== 1'h1) @(posedge clk);
    per(14);
    chk(nsh, 32'h0);
    chk(addr, a);
    chk(flag, a == 4'h0);
    chk(irq, 32'h1);
    bus(1'h0, `UCR_OFF_WORD, 32'h0);
    chk(r, {a, d});
    ins <= (a == 4'h0);
    per(14);
    if (a != 4'h0) begin
      chk(nsh, 32'hC);
      chk(got, d);
      bus(1'h1, `UCR_OFF_MASK, 32'h0);
      repeat (2) @(posedge clk);
      chk(irq, 32'h0);
      bus(1'h1, `UCR_OFF_MASK, 32'h7);
      per(1);
      chk(addr, 32'h0);
    end else begin
      chk(nsh, 32'h0);
      chk(flag, 32'h1);
      iwl <= 1'h1;
      per(14);
      chk(tsel, 32'h0);
      chk(nsh, 32'hC);
      chk(got, d);
      ins <= 1'h0;
      iwl <= 1'h0;
      per(1);
      chk(flag, 32'h0);
    end
    bus(1'h0, `UCR_OFF_STATUS, 32'h0);
    chk(r, exp_status(a));
    bus(1'h1, `UCR_OFF_STATUS, 32'h7);
    repeat (2) @(posedge clk);
    chk(irq, 32'h0);
  endtask
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    logic [3:0] a;
    logic [11:0] d;
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    chk(tsel, 32'h1);
    chk({addr, sh, flag, irq}, 32'h0);
    bus(1'h0, `UCR_OFF_CTRL, 32'h0);
    chk(r, 32'h1);
    bus(1'h0, `UCR_OFF_MASK, 32'h0);
    chk(r, 32'h0);
    bus(1'h0, 8'h40, 32'h0);
    chk(r, 32'h0);
    bus(1'h1, `UCR_OFF_MASK, 32'h7);
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      a = seed[15:12];
      if (a == 4'h0) a = 4'h1;
      if (i % 2 == 1) a = 4'h0;
      if (i == 0) a = 4'hF;
      d = seed[11:0];
      if (i == 1) d = 12'hFFF;
      slow <= seed[16];
      cmd(a, d);
    end
    bus(1'h1, `UCR_OFF_CTRL, 32'h0);
    bus(1'h0, `UCR_OFF_CTRL, 32'h0);
    chk(r, 32'h0);
    wv <= ~wv;
    @(posedge clk);
    go <= 1'h1;
    @(posedge clk);
    go <= 1'h0;
    per(0);
    while (cpl !== 1'h1) @(posedge clk);
    per(1);
    bus(1'h0, `UCR_OFF_WORD, 32'h0);
    chk(r, {a, d});
    results;
  end
endmodule // test_uplink_command_register
`default_nettype wire
